// *** src/cff_pkg.sv ***
/*
  Constants shared by the configurable FIFO block: flag modes, physical
  block geometry, default thresholds and widths.
  Assumes a single clock domain at 20 MHz and no register bus.
*/
`default_nettype none
package cff_pkg;
  // ---------------------------------------------------------------------
  // Flag configuration modes
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    CFF_FLAGS_NONE    = 2'h0,
    CFF_FLAGS_STATIC  = 2'h1,
    CFF_FLAGS_DYNAMIC = 2'h2
  } cff_flag_mode_t;

  // ---------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------
  localparam int CFF_REQ_DEPTH = 256;
  localparam int CFF_REQ_WIDTH = 8;
  localparam int CFF_PHYS_DEPTH = 512;
  localparam int CFF_PHYS_WIDTH = 9;
  localparam int CFF_MAX_BLOCKS = 64;
  localparam int CFF_BLOCKS_USED = 1;
  localparam int CFF_BUF_DEPTH = 16;
  localparam int CFF_PTR_W = 9;
  localparam int CFF_CNT_W = 10;

  // ---------------------------------------------------------------------
  // Threshold defaults
  // ---------------------------------------------------------------------
  localparam logic [CFF_CNT_W-1:0] CFF_AF_DEFAULT = 10'h002;
  localparam logic [CFF_CNT_W-1:0] CFF_AE_DEFAULT = 10'h001;
  localparam logic [CFF_CNT_W-1:0] CFF_CNT_ZERO = 10'h000;
  localparam logic [CFF_CNT_W-1:0] CFF_CNT_ONE = 10'h001;
  localparam logic [CFF_PTR_W-1:0] CFF_PTR_ZERO = 9'h000;
  localparam logic [CFF_PTR_W-1:0] CFF_PTR_ONE = 9'h001;
endpackage : cff_pkg
`default_nettype wire

// *** src/cff_stream_buf.sv ***
/*
  Small synchronous valid/ready FIFO used as the output staging buffer.
  Assumes one clock; width and depth are parameters, depth a power of two.
*/
`default_nettype none
module cff_stream_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic do_wr;
  logic do_rd;
  logic empty;
  logic full;

  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rp_q[AW-1:0]];
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
    end else if (do_wr) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rp_q <= '0;
    end else if (do_rd) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule // cff_stream_buf
`default_nettype wire

// *** src/cff_fifo.sv ***
/*
  Configurable FIFO with full/empty, almost-full and almost-empty flags,
  optional counter wrap past full or empty, and a 16-word output buffer.
  Assumes writer and reader are user logic on the same clk; choosing
  split clocks makes the FIFO refuse all traffic, since this
  build has one clock.
*/
// Overview of operation
// - Write counter wraps past full, keeps writing
// - Read counter wraps past empty, replays data
// - Full flag uses physical block depth
// - Threshold flags absent, fixed or run-time
// - Fixed thresholds from configuration, never changed
// - Run-time thresholds loaded from user registers
// - Single shared clock; independent clocks refuse all traffic
// - 256x8 request maps to 512x9 block
// - Cascades limited to 64 blocks
`default_nettype none
module cff_fifo
  import cff_pkg::*;
#(
  parameter cff_flag_mode_t FLAG_MODE = CFF_FLAGS_DYNAMIC,
  parameter bit WRAP_ON_FULL = 1'b0,
  parameter bit WRAP_ON_EMPTY = 1'b0,
  parameter bit SPLIT_CLOCKS = 1'b0,
  parameter bit THRESH_READ_UNITS = 1'b0,
  parameter int RD_PER_WR = 1,
  parameter logic [CFF_CNT_W-1:0] STATIC_AF = CFF_AF_DEFAULT,
  parameter logic [CFF_CNT_W-1:0] STATIC_AE = CFF_AE_DEFAULT,
  parameter int DATA_W = CFF_PHYS_WIDTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_en,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  input wire logic thr_load,
  input wire logic [CFF_CNT_W-1:0] thr_af_in,
  input wire logic [CFF_CNT_W-1:0] thr_ae_in,
  output logic full_q,
  output logic empty_q,
  output logic almost_full_q,
  output logic almost_empty_q,
  output logic [CFF_CNT_W-1:0] level_q,
  output logic overflow_q,
  output logic underflow_q
);
  // ---------------------------------------------------------------------
  // Configuration checks
  // ---------------------------------------------------------------------
  // Width is chosen before depth: an 8-bit request lands in the 9-bit
  // aspect ratio, so one 512x9 block holds 256x8 with room to spare.
  localparam int DEPTH = CFF_PHYS_DEPTH;
  localparam int BLOCKS = CFF_BLOCKS_USED;

  // Only the shared-clock build within the cascade and 9-bit width limits is implemented;
  // any other build refuses all traffic rather than corrupting the store.
  localparam bit CFG_OK = (BLOCKS <= CFF_MAX_BLOCKS) && (DATA_W <= CFF_PHYS_WIDTH)
                          && !SPLIT_CLOCKS;

  // ---------------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [CFF_PTR_W-1:0] wptr_q;
  logic [CFF_PTR_W-1:0] rptr_q;
  logic [DATA_W-1:0] rdata_q;
  logic rdata_vld_q;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  logic rd_vld_q;
  logic [DATA_W-1:0] rd_dat_q;
  logic is_full;
  logic is_empty;
  logic do_wr;
  logic do_rd;
  logic [CFF_CNT_W-1:0] level_d;

  assign is_full = (level_q == CFF_CNT_W'(DEPTH));
  assign is_empty = (level_q == CFF_CNT_ZERO);
  // Reads also stall while the staging slot cannot drain into the buffer.
  assign do_wr = CFG_OK && wr_en && (!is_full || WRAP_ON_FULL);
  assign do_rd = CFG_OK && rd_en && !(rdata_vld_q && !buf_in_ready)
                 && (!is_empty || WRAP_ON_EMPTY);

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wptr_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= CFF_PTR_ZERO;
    end else if (do_wr) begin
      wptr_q <= wptr_q + CFF_PTR_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rptr_q <= CFF_PTR_ZERO;
    end else if (do_rd) begin
      rptr_q <= rptr_q + CFF_PTR_ONE;
    end
  end

  // Level saturates in wrap modes; overwritten or replayed words are not
  // counted twice, which keeps the flags meaningful.
  always_comb begin
    level_d = level_q;
    if (do_wr && !do_rd && !is_full) begin
      level_d = level_q + CFF_CNT_ONE;
    end else if (do_rd && !do_wr && !is_empty) begin
      level_d = level_q - CFF_CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= CFF_CNT_ZERO;
    end else begin
      level_q <= level_d;
    end
  end

  // ---------------------------------------------------------------------
  // Read staging into the output buffer
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_vld_q <= 1'b0;
      rdata_q <= '0;
    end else if (do_rd) begin
      rdata_vld_q <= 1'b1;
      rdata_q <= mem_q[rptr_q];
    end else if (buf_in_ready) begin
      rdata_vld_q <= 1'b0;
    end
  end

  cff_stream_buf #(
    .WIDTH(DATA_W),
    .DEPTH(CFF_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(rdata_vld_q),
    .in_ready(buf_in_ready),
    .in_data(rdata_q),
    .out_valid(buf_out_valid),
    .out_ready(rd_ready && !(rd_vld_q && !rd_ready) || !rd_vld_q),
    .out_data(buf_out_data)
  );

  // Output register keeps every output straight from a flip-flop.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_vld_q <= 1'b0;
      rd_dat_q <= '0;
    end else if (!rd_vld_q || rd_ready) begin
      rd_vld_q <= buf_out_valid;
      rd_dat_q <= buf_out_data;
    end
  end

  assign rd_valid = rd_vld_q;
  assign rd_data = rd_dat_q;

  // ---------------------------------------------------------------------
  // Thresholds
  // ---------------------------------------------------------------------
  logic [CFF_CNT_W-1:0] af_thr_q;
  logic [CFF_CNT_W-1:0] ae_thr_q;
  logic [CFF_CNT_W-1:0] lvl_units;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      af_thr_q <= STATIC_AF;
      ae_thr_q <= STATIC_AE;
    end else if (FLAG_MODE == CFF_FLAGS_DYNAMIC && thr_load) begin
      af_thr_q <= thr_af_in;
      ae_thr_q <= thr_ae_in;
    end
  end

  // Read-word units scale the level by the read/write aspect ratio.
  // Next level, so the threshold flags line up with full and empty.
  assign lvl_units = THRESH_READ_UNITS ? CFF_CNT_W'(level_d * RD_PER_WR) : level_d;

  // ---------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_q <= 1'b0;
      empty_q <= 1'b1;
      almost_full_q <= 1'b0;
      almost_empty_q <= 1'b0;
    end else begin
      full_q <= (level_d == CFF_CNT_W'(DEPTH));
      empty_q <= (level_d == CFF_CNT_ZERO);
      if (FLAG_MODE == CFF_FLAGS_NONE) begin
        almost_full_q <= 1'b0;
        almost_empty_q <= 1'b0;
      end else begin
        almost_full_q <= (lvl_units >= af_thr_q);
        almost_empty_q <= (lvl_units <= ae_thr_q);
      end
    end
  end

  // Sticky error flags; they clear only on reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_q <= 1'b0;
      underflow_q <= 1'b0;
    end else begin
      if (wr_en && is_full && !WRAP_ON_FULL) begin
        overflow_q <= 1'b1;
      end
      if (rd_en && is_empty && !WRAP_ON_EMPTY) begin
        underflow_q <= 1'b1;
      end
    end
  end
endmodule // cff_fifo
`default_nettype wire

// *** dv/cff_sink.sv ***
/*
  Reader-side user logic for cff_fifo: pops output words into a queue.
  Assumes one clk shared with the FIFO and the async active-low reset.
*/
`default_nettype none
module cff_sink (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic rd_valid,
  input wire logic [8:0] rd_data,
  output logic rd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  logic [8:0] got[$];
  // Ready two cycles of four, so the output buffer fills and back-pressure shows
  assign rd_ready = cnt_q[1];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  always @(posedge clk) begin
    if (arst_n && rd_valid && rd_ready) got.push_back(rd_data);
  end
endmodule // cff_sink
`default_nettype wire

// *** dv/cff_fifo_properties.sv ***
/*
  Port checker for cff_fifo, bound to every instance.
  Takes the wrap and flag choices of the instance it is bound to; one clock.
*/
`default_nettype none
module cff_fifo_checker
  import cff_pkg::*;
#(
  parameter bit WRAP_F = 1'b0,
  parameter bit WRAP_E = 1'b0,
  parameter bit DYN_THR = 1'b1,
  parameter bit FLAGS_ON = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [8:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [8:0] rd_data,
  input wire logic thr_load,
  input wire logic [CFF_CNT_W-1:0] thr_af_in,
  input wire logic [CFF_CNT_W-1:0] thr_ae_in,
  input wire logic full_q,
  input wire logic empty_q,
  input wire logic almost_full_q,
  input wire logic almost_empty_q,
  input wire logic [CFF_CNT_W-1:0] level_q,
  input wire logic overflow_q,
  input wire logic underflow_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [CFF_CNT_W-1:0] af_q;
  logic [CFF_CNT_W-1:0] ae_q;
  logic up_q;
  // Threshold flags lag reset release by one edge, so their first edge is not judged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      af_q <= CFF_AF_DEFAULT;
      ae_q <= CFF_AE_DEFAULT;
      up_q <= 1'b0;
    end else begin
      up_q <= 1'b1;
      if (thr_load && DYN_THR) af_q <= thr_af_in;
      if (thr_load && DYN_THR) ae_q <= thr_ae_in;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_full; full_q == (level_q == 10'h200); endproperty
  a_full: assert property (p_full) else $error("full flag off level");
  property p_empty; empty_q == (level_q == 10'h000); endproperty
  a_empty: assert property (p_empty) else $error("empty flag off level");
  property p_af; up_q && !$past(thr_load) |-> almost_full_q == (FLAGS_ON && level_q >= af_q);
  endproperty
  a_af: assert property (p_af) else $error("almost full wrong");
  property p_ae; up_q && !$past(thr_load) |-> almost_empty_q == (FLAGS_ON && level_q <= ae_q);
  endproperty
  a_ae: assert property (p_ae) else $error("almost empty wrong");
  property p_ovf; wr_en && full_q |=> overflow_q == !WRAP_F; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not set");
  property p_udf; rd_en && empty_q |=> underflow_q == !WRAP_E; endproperty
  a_udf: assert property (p_udf) else $error("underflow not set");
  property p_hold; wr_en && !rd_en && full_q |=> full_q && $stable(level_q); endproperty
  a_hold: assert property (p_hold) else $error("full store changed");
  property p_inc; wr_en && !rd_en && !full_q |=> level_q == $past(level_q) + 10'h001;
  endproperty
  a_inc: assert property (p_inc) else $error("level not counted");
  property p_stand; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
  a_stand: assert property (p_stand) else $error("output word dropped");
  c_full: cover property (full_q);
  c_ovf: cover property (overflow_q);
  c_stall: cover property (rd_valid && !rd_ready);
endmodule // cff_fifo_checker
bind cff_fifo cff_fifo_checker #(
  .WRAP_F(WRAP_ON_FULL),
  .WRAP_E(WRAP_ON_EMPTY),
  .DYN_THR(FLAG_MODE == CFF_FLAGS_DYNAMIC),
  .FLAGS_ON(FLAG_MODE != CFF_FLAGS_NONE)
) u_chk (.clk, .arst_n, .wr_en, .wr_data, .rd_en, .rd_valid,
  .rd_ready, .rd_data, .thr_load, .thr_af_in, .thr_ae_in, .full_q, .empty_q, .almost_full_q,
  .almost_empty_q, .level_q, .overflow_q, .underflow_q);
`default_nettype wire

// *** dv/cff_fifo_tb.sv ***
/*
  Self-checking bench for cff_fifo: fill to physical depth, overflow,
  threshold reload, drain under back-pressure, underflow.
  Assumes default parameters and the cff_sink reader model.
*/
`default_nettype none
module cff_fifo_tb
  import cff_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, wr_en, rd_en, rd_valid, rd_ready, thr_load;
  logic full_q, empty_q, almost_full_q, almost_empty_q, overflow_q, underflow_q;
  logic [8:0] wr_data, rd_data;
  logic [CFF_CNT_W-1:0] thr_af_in, thr_ae_in, level_q;
  logic rd_en_w, rd_valid_w, rd_ready_w;
  logic full_w, empty_w, af_w, ae_w, overflow_w, underflow_w;
  logic [8:0] rd_data_w;
  logic [CFF_CNT_W-1:0] level_w;
  int n_mismatch = 0;
  int n_tests = 0;
  int k;
  always #25 clk = ~clk;
  cff_fifo dut (.clk, .arst_n, .wr_en, .wr_data, .rd_en, .rd_valid, .rd_ready, .rd_data,
    .thr_load, .thr_af_in, .thr_ae_in, .full_q, .empty_q, .almost_full_q, .almost_empty_q,
    .level_q, .overflow_q, .underflow_q);
  cff_sink u_sink (.clk, .arst_n, .rd_valid, .rd_data, .rd_ready);
  // Wrapping twin with fixed thresholds; it shares the writes and the threshold load
  cff_fifo #(
    .FLAG_MODE(CFF_FLAGS_STATIC),
    .WRAP_ON_FULL(1'b1),
    .WRAP_ON_EMPTY(1'b1)
  ) dut_w (.clk, .arst_n, .wr_en, .wr_data, .rd_en(rd_en_w), .rd_valid(rd_valid_w),
    .rd_ready(rd_ready_w), .rd_data(rd_data_w), .thr_load, .thr_af_in, .thr_ae_in,
    .full_q(full_w), .empty_q(empty_w), .almost_full_q(af_w), .almost_empty_q(ae_w),
    .level_q(level_w), .overflow_q(overflow_w), .underflow_q(underflow_w));
  cff_sink u_sink_w (.clk, .arst_n, .rd_valid(rd_valid_w), .rd_data(rd_data_w),
    .rd_ready(rd_ready_w));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic write_n(input int n, input int base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_en <= 1'b1;
      wr_data <= 9'(base + i);
    end
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  initial begin
    {clk, arst_n, wr_en, rd_en, thr_load} = 5'h00;
    wr_data = 9'h000;
    rd_en_w = 1'b0;
    thr_af_in = 10'h000;
    thr_ae_in = 10'h000;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    tick();
    chk(empty_q, 1'b1);
    chk(almost_empty_q, 1'b1);
    write_n(256, 0);
    tick();
    chk(full_q, 1'b0);
    write_n(256, 256);
    tick();
    chk({full_q, almost_full_q, level_q}, 12'hE00);
    // The twin takes this word over address 0; the plain FIFO drops it
    write_n(1, 9'h155);
    tick();
    chk({overflow_q, level_q}, 11'h600);
    chk({overflow_w, level_w}, 11'h200);
    // Run-time thresholds: new values govern flags from the edge after the load
    @(posedge clk);
    thr_load <= 1'b1;
    thr_af_in <= 10'h3FF;
    thr_ae_in <= 10'h200;
    @(posedge clk);
    thr_load <= 1'b0;
    tick();
    chk({almost_full_q, almost_empty_q}, 2'h1);
    chk({af_w, ae_w}, 2'h2);
    @(posedge clk);
    rd_en <= 1'b1;
    k = 0;
    while (empty_q !== 1'b1) begin
      tick();
      if (++k > 3000) begin
        n_mismatch++;
        test_done();
      end
    end
    @(posedge clk);
    rd_en <= 1'b0;
    tick();
    chk(underflow_q, 1'b1);
    // Drain the twin, then keep reading past empty so it replays
    @(posedge clk);
    rd_en_w <= 1'b1;
    k = 0;
    while (empty_w !== 1'b1) begin
      tick();
      if (++k > 3000) begin
        n_mismatch++;
        test_done();
      end
    end
    repeat (40) @(posedge clk);
    rd_en_w <= 1'b0;
    tick();
    chk({overflow_w, underflow_w}, 2'h0);
    k = 0;
    while ((u_sink.got.size() < 512 || u_sink_w.got.size() < 513) && k < 3000) begin
      tick();
      k++;
    end
    chk(u_sink_w.got[0], 16'h0155);
    chk(u_sink_w.got[512], 16'h0155);
    chk(16'(u_sink_w.got.size() > 512), 16'h0001);
    chk(16'(u_sink.got.size()), 16'h0200);
    foreach (u_sink.got[i]) chk(u_sink.got[i], 16'(i[8:0]));
    test_done();
  end
endmodule // cff_fifo_tb
`default_nettype wire
